//--- dv/rpd_lowside_model.sv
// Low-side single channel model turning duty and frequency into coil drive.
// Assumes duty is Q8.8 percent; the period is a fixed 100 steps of CLK.
`timescale 1ns/1ps
module rpd_lowside_model (
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire rpd_pkg::rpd_val_t CHAN_DUTY,
  input  wire logic [15:0]       CHAN_FREQ,
  input  wire logic              CHAN_ON,
  output logic                   DRIVE
);
  logic [6:0] step_reg;
  always_ff @(posedge CLK) begin
    if (RESET || step_reg == 7'h63) begin
      step_reg <= 7'h00;
    end else begin
      step_reg <= step_reg + 7'h01;
    end
  end
  // Real period follows CHAN_FREQ; a fixed one keeps the model small
  assign DRIVE = CHAN_ON && (CHAN_FREQ != 16'h0000) &&
                 ({1'b0, step_reg} < CHAN_DUTY[15:8]);
endmodule

//--- dv/rpd_rail_pressure_pid_duty_tb.sv
// Self-checking bench for the dual valve duty block.
// Assumes UPDATE_CYCLES of 8 and settled outputs 24 cycles after a change.
`timescale 1ns/1ps
module rpd_rail_pressure_pid_duty_tb;
  logic CLK = 1'b0, RESET = 1'b1, OVERPRESSURE_CLEAR = 1'b0;
  rpd_pkg::rpd_loop_t LOOP_VALVE_SELECT = rpd_pkg::RPD_LOOP_INLET;
  rpd_pkg::rpd_val_t SETPOINT = 16'sh0A00, RAIL_PRESSURE = 16'sh0500;
  rpd_pkg::rpd_val_t BATTERY_VOLTS = 16'sh0C00;
  rpd_pkg::rpd_val_t OVERPRESSURE_THRESHOLD = 16'sh6400;
  rpd_pkg::rpd_val_t INLET_PROP_GAIN = 16'sh0000;
  rpd_pkg::rpd_val_t INLET_CTRL_MAX = 16'sh1E00;
  rpd_pkg::rpd_val_t INLET_CTRL_MIN = 16'shEC00;
  rpd_pkg::rpd_val_t INLET_LOOP_FEEDFORWARD = 16'sh0A00;
  rpd_pkg::rpd_val_t INLET_OPEN_LOOP_FEEDFORWARD = 16'sh1400;
  rpd_pkg::rpd_val_t INLET_MANUAL_DUTY = 16'sh3200;
  rpd_pkg::rpd_val_t INLET_USER_MAX_DUTY = 16'sh6400;
  rpd_pkg::rpd_val_t INLET_MIN_DUTY = 16'sh0000;
  rpd_pkg::rpd_val_t INLET_COIL_OHMS = 16'sh0280;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_PROP_GAIN = 16'sh0100;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_CTRL_MAX = 16'sh1E00;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_CTRL_MIN = 16'shEC00;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_LOOP_FEEDFORWARD = 16'sh1E00;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_OPEN_LOOP_FEEDFORWARD = 16'sh1400;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_MANUAL_DUTY = 16'sh3200;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_USER_MAX_DUTY = 16'sh6400;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_MIN_DUTY = 16'sh0000;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_COIL_OHMS = 16'sh0300;
  // Time constants stay non-negative by being unsigned
  logic [15:0] INLET_INTEGRAL_TIME = 16'h0000;
  logic [15:0] INLET_DERIVATIVE_TIME = 16'h0000;
  logic [15:0] PRESSURE_VALVE_INTEGRAL_TIME = 16'h0000;
  logic [15:0] PRESSURE_VALVE_DERIVATIVE_TIME = 16'h0000;
  logic [15:0] INLET_PWM_FREQ = 16'h01F4, PRESSURE_VALVE_PWM_FREQ = 16'h03E8;
  logic INLET_MANUAL_SELECT = 1'b0, INLET_DRIVE_ENABLE = 1'b1;
  logic PRESSURE_VALVE_MANUAL_SELECT = 1'b0;
  logic PRESSURE_VALVE_DRIVE_ENABLE = 1'b1;
  rpd_pkg::rpd_val_t INLET_PROP_TERM, INLET_INTEGRAL_TERM, INLET_DERIV_TERM;
  rpd_pkg::rpd_val_t INLET_CTRL_OUTPUT, INLET_CURRENT_LIMIT_DUTY;
  rpd_pkg::rpd_val_t INLET_FINAL_DUTY, INLET_CURRENT_ESTIMATE;
  rpd_pkg::rpd_val_t INLET_CHAN_DUTY, PRESSURE_VALVE_PROP_TERM;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_INTEGRAL_TERM, PRESSURE_VALVE_DERIV_TERM;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_CTRL_OUTPUT;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_CURRENT_LIMIT_DUTY;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_FINAL_DUTY;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_CURRENT_ESTIMATE;
  rpd_pkg::rpd_val_t PRESSURE_VALVE_CHAN_DUTY;
  logic [15:0] INLET_CHAN_FREQ, PRESSURE_VALVE_CHAN_FREQ;
  logic INLET_CHAN_ON, PRESSURE_VALVE_CHAN_ON, OVERPRESSURE_FAULT;
  logic drive_in, drive_pv;
  int n_errors = 0;
  int total_checks = 0;

  always #2 CLK = ~CLK;

  rpd_rail_pressure_pid_duty #(.UPDATE_CYCLES(8))
    rpd_rail_pressure_pid_duty_inst (.*);
  rpd_lowside_model rpd_lowside_model_inst (.CLK(CLK), .RESET(RESET),
    .CHAN_DUTY(INLET_CHAN_DUTY), .CHAN_FREQ(INLET_CHAN_FREQ),
    .CHAN_ON(INLET_CHAN_ON), .DRIVE(drive_in));
  rpd_lowside_model rpd_lowside_model_pv_inst (.CLK(CLK), .RESET(RESET),
    .CHAN_DUTY(PRESSURE_VALVE_CHAN_DUTY),
    .CHAN_FREQ(PRESSURE_VALVE_CHAN_FREQ),
    .CHAN_ON(PRESSURE_VALVE_CHAN_ON), .DRIVE(drive_pv));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Covers the controller tick period plus the two output stages
  task automatic settle;
    repeat (24) @(posedge CLK);
    #1;
  endtask

  task automatic t_open_loop;
    settle();
    chk(INLET_CTRL_OUTPUT, 16'h0000);
    chk(INLET_FINAL_DUTY, 16'h0A00);
    chk(INLET_CHAN_DUTY, 16'h0A00);
    chk(PRESSURE_VALVE_FINAL_DUTY, 16'h1400);
    chk(PRESSURE_VALVE_PROP_TERM, 16'h0000);
    chk(INLET_CURRENT_LIMIT_DUTY, 16'h3E80);
    chk(PRESSURE_VALVE_CURRENT_LIMIT_DUTY, 16'h4B00);
    chk(INLET_CURRENT_ESTIMATE, 16'h007A);
    chk(INLET_CHAN_FREQ, 16'h01F4);
    chk(PRESSURE_VALVE_CHAN_FREQ, 16'h03E8);
    @(posedge CLK);
    LOOP_VALVE_SELECT <= rpd_pkg::RPD_LOOP_PRESSURE;
    PRESSURE_VALVE_PROP_GAIN <= 16'sh0000;
    settle();
    chk(PRESSURE_VALVE_FINAL_DUTY, 16'h1E00);
    chk(INLET_FINAL_DUTY, 16'h1400);
    chk(PRESSURE_VALVE_CTRL_OUTPUT | PRESSURE_VALVE_INTEGRAL_TERM |
        PRESSURE_VALVE_DERIV_TERM, 16'h0000);
    chk(PRESSURE_VALVE_CURRENT_ESTIMATE, 16'h0133);
    @(posedge CLK);
    LOOP_VALVE_SELECT <= rpd_pkg::RPD_LOOP_INLET;
    $display("test open_loop done");
  endtask

  task automatic t_pid;
    rpd_pkg::rpd_val_t i_seen;
    @(posedge CLK);
    INLET_PROP_GAIN <= 16'sh0100;
    settle();
    chk(INLET_PROP_TERM, 16'h0500);
    chk(INLET_INTEGRAL_TERM, 16'h0000);
    chk(INLET_FINAL_DUTY, 16'h0F00);
    // A one-LSB error step kicks the derivative for a single tick
    @(posedge CLK);
    SETPOINT <= 16'sh0A01;
    INLET_DERIVATIVE_TIME <= 16'h0001;
    for (int k = 0; k < 16 && INLET_DERIV_TERM == 16'sh0000; k++) begin
      @(posedge CLK);
      #1;
    end
    chk(INLET_DERIV_TERM, 16'h003C);
    settle();
    chk(INLET_DERIV_TERM, 16'h0000);
    // One tick apart the integral grows by prop / (time * 60)
    @(posedge CLK);
    INLET_DERIVATIVE_TIME <= 16'h0000;
    INLET_INTEGRAL_TIME <= 16'h0001;
    settle();
    i_seen = INLET_INTEGRAL_TERM;
    repeat (8) @(posedge CLK);
    #1;
    chk(INLET_INTEGRAL_TERM - i_seen, 16'h0015);
    @(posedge CLK);
    INLET_INTEGRAL_TIME <= 16'h0002;
    settle();
    i_seen = INLET_INTEGRAL_TERM;
    repeat (8) @(posedge CLK);
    #1;
    chk(INLET_INTEGRAL_TERM - i_seen, 16'h000A);
    @(posedge CLK);
    SETPOINT <= 16'sh0A00;
    INLET_INTEGRAL_TIME <= 16'h0000;
    INLET_PROP_GAIN <= 16'shFF00;
    settle();
    chk(INLET_INTEGRAL_TERM, 16'h0000);
    chk(INLET_CTRL_OUTPUT, 16'hFB00);
    chk(INLET_FINAL_DUTY, 16'h0500);
    @(posedge CLK);
    SETPOINT <= 16'sh0F00;
    INLET_PROP_GAIN <= 16'sh0400;
    settle();
    chk(INLET_PROP_TERM, 16'h2800);
    chk(INLET_DERIV_TERM, 16'h0000);
    chk(INLET_CTRL_OUTPUT, 16'h1E00);
    chk(INLET_FINAL_DUTY, 16'h2800);
    @(posedge CLK);
    INLET_PROP_GAIN <= 16'shFC00;
    settle();
    chk(INLET_CTRL_OUTPUT, 16'hEC00);
    chk(INLET_FINAL_DUTY, 16'h0000);
    $display("test pid done");
  endtask

  task automatic t_limits;
    @(posedge CLK);
    INLET_MANUAL_SELECT <= 1'b1;
    settle();
    chk(INLET_FINAL_DUTY, 16'h3200);
    chk(INLET_CURRENT_ESTIMATE, 16'h0266);
    @(posedge CLK);
    INLET_MANUAL_DUTY <= 16'sh5A00;
    settle();
    chk(INLET_FINAL_DUTY, 16'h3E80);
    @(posedge CLK);
    INLET_USER_MAX_DUTY <= 16'sh2800;
    settle();
    chk(INLET_FINAL_DUTY, 16'h2800);
    @(posedge CLK);
    INLET_MIN_DUTY <= 16'sh2D00;
    settle();
    chk(INLET_FINAL_DUTY, 16'h2D00);
    $display("test limits done");
  endtask

  task automatic t_gate;
    @(posedge CLK);
    INLET_DRIVE_ENABLE <= 1'b0;
    settle();
    chk({INLET_CHAN_FREQ | INLET_CHAN_DUTY}, 16'h0000);
    chk({15'h0000, INLET_CHAN_ON | drive_in}, 16'h0000);
    chk(PRESSURE_VALVE_CHAN_DUTY, 16'h1400);
    @(posedge CLK);
    INLET_DRIVE_ENABLE <= 1'b1;
    RAIL_PRESSURE <= 16'sh6400;
    settle();
    chk({15'h0000, OVERPRESSURE_FAULT}, 16'h0000);
    @(posedge CLK);
    RAIL_PRESSURE <= 16'sh6401;
    OVERPRESSURE_CLEAR <= 1'b1;
    settle();
    chk({14'h0000, OVERPRESSURE_FAULT, INLET_CHAN_ON}, 16'h0002);
    chk({15'h0000, PRESSURE_VALVE_CHAN_ON | drive_pv}, 16'h0000);
    @(posedge CLK);
    RAIL_PRESSURE <= 16'sh0500;
    settle();
    chk({14'h0000, OVERPRESSURE_FAULT, INLET_CHAN_ON}, 16'h0001);
    $display("test gate done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge CLK);
    #1;
    chk(INLET_FINAL_DUTY | PRESSURE_VALVE_FINAL_DUTY, 16'h0000);
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    t_open_loop();
    t_pid();
    t_limits();
    t_gate();
    results();
  end
endmodule

//--- verilog/rpd_cfg.svh
// Constants for the rail pressure valve duty block.
// Assumes a 250 MHz clock; values are signed Q8.8 unless noted.
//
// Contract
// - Integral time zero drops the integral term; smaller gives more.
// - Derivative time zero drops the derivative term; larger gives more.
// - Zero proportional gain zeroes all three controller terms.
// - Negative gain makes output act against setpoint minus pressure.
// - Controller output saturates between its minimum and maximum limit.
// - Controller limits apply before feed forward is added.
// - Feed forward plus limited controller output forms final duty.
// - Loop feed forward counts only while its valve is loop-selected.
// - Valve not in the loop gets its open-loop feed forward duty.
// - Manual select bypasses the controller with the manual duty.
// - Current-limit duty from battery and coil ohms keeps 3 A.
// - User maximum duty governs only when below current-limit duty.
// - Final duty never falls below the valve's minimum duty.
// - Drive enable gates duty and frequency to the valve's channels.
// - Current estimate from final duty, battery and coil ohms, ungated by drive enable or fault.
// - Each valve's PWM runs at its own frequency in hertz.
// - Proportional, integral and derivative terms are readable.
// - Mode selects the loop valve; the other runs at constant duty.
// - Overpressure latches a fault that turns both valves off.
`ifndef RPD_CFG_SVH
`define RPD_CFG_SVH
`define RPD_FRAC        8
`define RPD_CLK_NS      4
`define RPD_UPDATE_MS   1
`define RPD_UPDATE_CYC  (`RPD_UPDATE_MS * 1000000 / `RPD_CLK_NS)
`define RPD_MS_PER_MMIN 60
`define RPD_I_LIMIT_A   3
`define RPD_PCT         100
`define RPD_PCT_FULL    16'sh6400
`define RPD_ZERO        16'sh0000
`endif

//--- verilog/rpd_pkg.sv
// Types for the rail pressure valve duty block.
// Assumes nothing beyond the constants header.
package rpd_pkg;
  typedef enum logic [0:0] {
    RPD_LOOP_INLET    = 1'b0,
    RPD_LOOP_PRESSURE = 1'b1
  } rpd_loop_t;
  typedef logic signed [15:0] rpd_val_t;
endpackage

//--- verilog/rpd_rail_pressure_pid_duty.sv
// Dual valve rail pressure controller producing duty and frequency.
// Assumes configuration inputs come from logic on CLK; index 0 is the
// inlet metering valve, index 1 the high pressure valve.
`timescale 1ns/1ps
`include "rpd_cfg.svh"
module rpd_rail_pressure_pid_duty #(
  parameter int unsigned UPDATE_CYCLES = `RPD_UPDATE_CYC
) (
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire rpd_pkg::rpd_val_t SETPOINT,
  input  wire rpd_pkg::rpd_val_t RAIL_PRESSURE,
  input  wire rpd_pkg::rpd_val_t BATTERY_VOLTS,
  input  wire rpd_pkg::rpd_val_t OVERPRESSURE_THRESHOLD,
  input  wire logic              OVERPRESSURE_CLEAR,
  input  wire rpd_pkg::rpd_loop_t LOOP_VALVE_SELECT,
  input  wire rpd_pkg::rpd_val_t INLET_PROP_GAIN,
  input  wire logic [15:0]       INLET_INTEGRAL_TIME,
  input  wire logic [15:0]       INLET_DERIVATIVE_TIME,
  input  wire rpd_pkg::rpd_val_t INLET_CTRL_MAX,
  input  wire rpd_pkg::rpd_val_t INLET_CTRL_MIN,
  input  wire rpd_pkg::rpd_val_t INLET_LOOP_FEEDFORWARD,
  input  wire rpd_pkg::rpd_val_t INLET_OPEN_LOOP_FEEDFORWARD,
  input  wire logic              INLET_MANUAL_SELECT,
  input  wire rpd_pkg::rpd_val_t INLET_MANUAL_DUTY,
  input  wire rpd_pkg::rpd_val_t INLET_USER_MAX_DUTY,
  input  wire rpd_pkg::rpd_val_t INLET_MIN_DUTY,
  input  wire rpd_pkg::rpd_val_t INLET_COIL_OHMS,
  input  wire logic              INLET_DRIVE_ENABLE,
  input  wire logic [15:0]       INLET_PWM_FREQ,
  input  wire rpd_pkg::rpd_val_t PRESSURE_VALVE_PROP_GAIN,
  input  wire logic [15:0]       PRESSURE_VALVE_INTEGRAL_TIME,
  input  wire logic [15:0]       PRESSURE_VALVE_DERIVATIVE_TIME,
  input  wire rpd_pkg::rpd_val_t PRESSURE_VALVE_CTRL_MAX,
  input  wire rpd_pkg::rpd_val_t PRESSURE_VALVE_CTRL_MIN,
  input  wire rpd_pkg::rpd_val_t PRESSURE_VALVE_LOOP_FEEDFORWARD,
  input  wire rpd_pkg::rpd_val_t PRESSURE_VALVE_OPEN_LOOP_FEEDFORWARD,
  input  wire logic              PRESSURE_VALVE_MANUAL_SELECT,
  input  wire rpd_pkg::rpd_val_t PRESSURE_VALVE_MANUAL_DUTY,
  input  wire rpd_pkg::rpd_val_t PRESSURE_VALVE_USER_MAX_DUTY,
  input  wire rpd_pkg::rpd_val_t PRESSURE_VALVE_MIN_DUTY,
  input  wire rpd_pkg::rpd_val_t PRESSURE_VALVE_COIL_OHMS,
  input  wire logic              PRESSURE_VALVE_DRIVE_ENABLE,
  input  wire logic [15:0]       PRESSURE_VALVE_PWM_FREQ,
  output rpd_pkg::rpd_val_t      INLET_PROP_TERM,
  output rpd_pkg::rpd_val_t      INLET_INTEGRAL_TERM,
  output rpd_pkg::rpd_val_t      INLET_DERIV_TERM,
  output rpd_pkg::rpd_val_t      INLET_CTRL_OUTPUT,
  output rpd_pkg::rpd_val_t      INLET_CURRENT_LIMIT_DUTY,
  output rpd_pkg::rpd_val_t      INLET_FINAL_DUTY,
  output rpd_pkg::rpd_val_t      INLET_CURRENT_ESTIMATE,
  output rpd_pkg::rpd_val_t      INLET_CHAN_DUTY,
  output logic [15:0]            INLET_CHAN_FREQ,
  output logic                   INLET_CHAN_ON,
  output rpd_pkg::rpd_val_t      PRESSURE_VALVE_PROP_TERM,
  output rpd_pkg::rpd_val_t      PRESSURE_VALVE_INTEGRAL_TERM,
  output rpd_pkg::rpd_val_t      PRESSURE_VALVE_DERIV_TERM,
  output rpd_pkg::rpd_val_t      PRESSURE_VALVE_CTRL_OUTPUT,
  output rpd_pkg::rpd_val_t      PRESSURE_VALVE_CURRENT_LIMIT_DUTY,
  output rpd_pkg::rpd_val_t      PRESSURE_VALVE_FINAL_DUTY,
  output rpd_pkg::rpd_val_t      PRESSURE_VALVE_CURRENT_ESTIMATE,
  output rpd_pkg::rpd_val_t      PRESSURE_VALVE_CHAN_DUTY,
  output logic [15:0]            PRESSURE_VALVE_CHAN_FREQ,
  output logic                   PRESSURE_VALVE_CHAN_ON,
  output logic                   OVERPRESSURE_FAULT
);

  function automatic rpd_pkg::rpd_val_t sat(input logic signed [47:0] x);
    if (x > 48'sh0000_0000_7FFF) return 16'sh7FFF;
    if (x < -48'sh0000_0000_8000) return 16'sh8000;
    return x[15:0];
  endfunction

  // Upper bound first, so a minimum above the maximum still wins
  function automatic rpd_pkg::rpd_val_t lim(input rpd_pkg::rpd_val_t x,
                                            input rpd_pkg::rpd_val_t lo,
                                            input rpd_pkg::rpd_val_t hi);
    rpd_pkg::rpd_val_t y;
    y = (x > hi) ? hi : x;
    return (y < lo) ? lo : y;
  endfunction

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  rpd_pkg::rpd_val_t kc [2], cmax [2], cmin [2], lff [2], off [2];
  rpd_pkg::rpd_val_t mduty [2], umax [2], dmin [2], ohms [2];
  logic [15:0]       ti [2], td [2], freq [2];
  logic              man [2], en [2];

  assign kc[0]    = INLET_PROP_GAIN;
  assign kc[1]    = PRESSURE_VALVE_PROP_GAIN;
  assign ti[0]    = INLET_INTEGRAL_TIME;
  assign ti[1]    = PRESSURE_VALVE_INTEGRAL_TIME;
  assign td[0]    = INLET_DERIVATIVE_TIME;
  assign td[1]    = PRESSURE_VALVE_DERIVATIVE_TIME;
  assign cmax[0]  = INLET_CTRL_MAX;
  assign cmax[1]  = PRESSURE_VALVE_CTRL_MAX;
  assign cmin[0]  = INLET_CTRL_MIN;
  assign cmin[1]  = PRESSURE_VALVE_CTRL_MIN;
  assign lff[0]   = INLET_LOOP_FEEDFORWARD;
  assign lff[1]   = PRESSURE_VALVE_LOOP_FEEDFORWARD;
  assign off[0]   = INLET_OPEN_LOOP_FEEDFORWARD;
  assign off[1]   = PRESSURE_VALVE_OPEN_LOOP_FEEDFORWARD;
  assign man[0]   = INLET_MANUAL_SELECT;
  assign man[1]   = PRESSURE_VALVE_MANUAL_SELECT;
  assign mduty[0] = INLET_MANUAL_DUTY;
  assign mduty[1] = PRESSURE_VALVE_MANUAL_DUTY;
  assign umax[0]  = INLET_USER_MAX_DUTY;
  assign umax[1]  = PRESSURE_VALVE_USER_MAX_DUTY;
  assign dmin[0]  = INLET_MIN_DUTY;
  assign dmin[1]  = PRESSURE_VALVE_MIN_DUTY;
  assign ohms[0]  = INLET_COIL_OHMS;
  assign ohms[1]  = PRESSURE_VALVE_COIL_OHMS;
  assign en[0]    = INLET_DRIVE_ENABLE;
  assign en[1]    = PRESSURE_VALVE_DRIVE_ENABLE;
  assign freq[0]  = INLET_PWM_FREQ;
  assign freq[1]  = PRESSURE_VALVE_PWM_FREQ;

  // Controller update tick and overpressure latch
  logic [31:0] tcnt_reg, tcnt_next;
  logic        tick_reg, tick_next, fault_reg, fault_next;

  always_comb begin
    tick_next  = (tcnt_reg == 32'(UPDATE_CYCLES - 1));
    tcnt_next  = tick_next ? 32'h0000_0000 : tcnt_reg + 32'h0000_0001;
    // A new overpressure beats a clear in the same cycle
    fault_next = (RAIL_PRESSURE > OVERPRESSURE_THRESHOLD) ||
                 (fault_reg && !OVERPRESSURE_CLEAR);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      tcnt_reg  <= 32'h0000_0000;
      tick_reg  <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      tcnt_reg  <= tcnt_next;
      tick_reg  <= tick_next;
      fault_reg <= fault_next;
    end
  end

  assign OVERPRESSURE_FAULT = fault_reg;

  sequence s_over;
    RAIL_PRESSURE > OVERPRESSURE_THRESHOLD;
  endsequence
  property p_fault_set;
    s_over |=> fault_reg ##1 (fault_reg || $past(OVERPRESSURE_CLEAR));
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("overpressure not latched");

  rpd_pkg::rpd_val_t p_reg [2], i_reg [2], d_reg [2], c_reg [2];
  rpd_pkg::rpd_val_t e_reg [2], calc_reg [2], duty_reg [2], cur_reg [2];
  rpd_pkg::rpd_val_t cd_reg [2];
  logic [15:0]       cf_reg [2];
  logic              on_reg [2];

  for (genvar v = 0; v < 2; v++) begin : g_valve
    rpd_pkg::rpd_val_t p_next, i_next, d_next, c_next, e_next, calc_next;
    rpd_pkg::rpd_val_t duty_next, cur_next, cd_next, base, ceil_d;
    logic [15:0]       cf_next;
    logic              on_next, in_loop;
    logic signed [47:0] err, prop, dprop, iinc, dterm, num;

    always_comb begin
      in_loop = (LOOP_VALVE_SELECT == rpd_pkg::rpd_loop_t'(1'(v)));
      err   = 48'(SETPOINT) - 48'(RAIL_PRESSURE);
      prop  = (48'(kc[v]) * err) >>> `RPD_FRAC;
      dprop = (48'(kc[v]) * (err - 48'(e_reg[v]))) >>> `RPD_FRAC;
      // Times are milliminutes; one milliminute is 60 ms
      iinc  = (ti[v] == 16'h0000) ? 48'sh0 :
              prop * `RPD_UPDATE_MS /
              (48'($signed({1'b0, ti[v]})) * `RPD_MS_PER_MMIN);
      dterm = (td[v] == 16'h0000) ? 48'sh0 :
              dprop * 48'($signed({1'b0, td[v]})) * `RPD_MS_PER_MMIN /
              `RPD_UPDATE_MS;
      p_next = p_reg[v];
      i_next = i_reg[v];
      d_next = d_reg[v];
      c_next = c_reg[v];
      e_next = e_reg[v];
      if (tick_reg) begin
        e_next = sat(err);
        if (!in_loop || man[v] || kc[v] == `RPD_ZERO) begin
          p_next = `RPD_ZERO;
          i_next = `RPD_ZERO;
          d_next = `RPD_ZERO;
        end else begin
          p_next = sat(prop);
          // Integral held inside limits to stop windup; zero time drops it
          if (ti[v] == 16'h0000)
            i_next = `RPD_ZERO;
          else
            i_next = lim(sat(48'(i_reg[v]) + iinc), cmin[v], cmax[v]);
          d_next = sat(dterm);
        end
        c_next = lim(sat(48'(p_next) + 48'(i_next) + 48'(d_next)),
                     cmin[v], cmax[v]);
      end
      if (man[v])
        base = mduty[v];
      else if (in_loop)
        base = sat(48'(c_reg[v]) + 48'(lff[v]));
      else
        base = off[v];
      num = 48'(`RPD_I_LIMIT_A * `RPD_PCT) * 48'(ohms[v]) <<< `RPD_FRAC;
      if (BATTERY_VOLTS <= `RPD_ZERO)
        calc_next = `RPD_PCT_FULL;
      else
        calc_next = lim(sat(num / 48'(BATTERY_VOLTS)), `RPD_ZERO,
                        `RPD_PCT_FULL);
      ceil_d = (umax[v] < calc_reg[v]) ? umax[v] : calc_reg[v];
      duty_next = lim(base, dmin[v], ceil_d);
      if (ohms[v] <= `RPD_ZERO)
        cur_next = `RPD_ZERO;
      else
        cur_next = sat(48'(duty_reg[v]) * 48'(BATTERY_VOLTS) /
                       (48'(ohms[v]) * `RPD_PCT));
      on_next = en[v] && !fault_next;
      cd_next = on_next ? duty_next : `RPD_ZERO;
      cf_next = on_next ? freq[v] : 16'h0000;
    end

    always_ff @(posedge CLK) begin
      if (RESET) begin
        p_reg[v]    <= `RPD_ZERO;
        i_reg[v]    <= `RPD_ZERO;
        d_reg[v]    <= `RPD_ZERO;
        c_reg[v]    <= `RPD_ZERO;
        e_reg[v]    <= `RPD_ZERO;
        calc_reg[v] <= `RPD_ZERO;
        duty_reg[v] <= `RPD_ZERO;
        cur_reg[v]  <= `RPD_ZERO;
        cd_reg[v]   <= `RPD_ZERO;
        cf_reg[v]   <= 16'h0000;
        on_reg[v]   <= 1'b0;
      end else begin
        p_reg[v]    <= p_next;
        i_reg[v]    <= i_next;
        d_reg[v]    <= d_next;
        c_reg[v]    <= c_next;
        e_reg[v]    <= e_next;
        calc_reg[v] <= calc_next;
        duty_reg[v] <= duty_next;
        cur_reg[v]  <= cur_next;
        cd_reg[v]   <= cd_next;
        cf_reg[v]   <= cf_next;
        on_reg[v]   <= on_next;
      end
    end

    property p_kc_zero;
      tick_reg && kc[v] == `RPD_ZERO |=>
        p_reg[v] == `RPD_ZERO && i_reg[v] == `RPD_ZERO &&
        d_reg[v] == `RPD_ZERO;
    endproperty
    a_kc_zero: assert property (p_kc_zero)
      else $error("terms not zero at zero gain");
    property p_ti_zero;
      tick_reg && ti[v] == 16'h0000 |=> i_reg[v] == `RPD_ZERO;
    endproperty
    a_ti_zero: assert property (p_ti_zero)
      else $error("integral moved at zero time");
    property p_td_zero;
      tick_reg && td[v] == 16'h0000 |=> d_reg[v] == `RPD_ZERO;
    endproperty
    a_td_zero: assert property (p_td_zero)
      else $error("derivative nonzero at zero time");
    property p_ctrl_lim;
      tick_reg && cmin[v] <= cmax[v] |=>
        c_reg[v] <= $past(cmax[v]) && c_reg[v] >= $past(cmin[v]);
    endproperty
    a_ctrl_lim: assert property (p_ctrl_lim)
      else $error("controller output outside limits");
    property p_min_duty;
      ##1 duty_reg[v] >= $past(dmin[v]);
    endproperty
    a_min_duty: assert property (p_min_duty)
      else $error("duty below minimum");
    property p_manual;
      man[v] && mduty[v] >= dmin[v] && mduty[v] <= umax[v] &&
        mduty[v] <= calc_reg[v] |=> duty_reg[v] == $past(mduty[v]);
    endproperty
    a_manual: assert property (p_manual)
      else $error("manual duty not applied");
    // The channel flops load with the fault flop, so the fault is same-cycle
    property p_gate;
      (!en[v] |=> !on_reg[v] && cd_reg[v] == `RPD_ZERO &&
        cf_reg[v] == 16'h0000) and
      (fault_reg |-> !on_reg[v] && cd_reg[v] == `RPD_ZERO &&
        cf_reg[v] == 16'h0000);
    endproperty
    a_gate: assert property (p_gate)
      else $error("channel driven while gated");
  end

  assign INLET_PROP_TERM                   = p_reg[0];
  assign INLET_INTEGRAL_TERM               = i_reg[0];
  assign INLET_DERIV_TERM                  = d_reg[0];
  assign INLET_CTRL_OUTPUT                 = c_reg[0];
  assign INLET_CURRENT_LIMIT_DUTY          = calc_reg[0];
  assign INLET_FINAL_DUTY                  = duty_reg[0];
  assign INLET_CURRENT_ESTIMATE            = cur_reg[0];
  assign INLET_CHAN_DUTY                   = cd_reg[0];
  assign INLET_CHAN_FREQ                   = cf_reg[0];
  assign INLET_CHAN_ON                     = on_reg[0];
  assign PRESSURE_VALVE_PROP_TERM          = p_reg[1];
  assign PRESSURE_VALVE_INTEGRAL_TERM      = i_reg[1];
  assign PRESSURE_VALVE_DERIV_TERM         = d_reg[1];
  assign PRESSURE_VALVE_CTRL_OUTPUT        = c_reg[1];
  assign PRESSURE_VALVE_CURRENT_LIMIT_DUTY = calc_reg[1];
  assign PRESSURE_VALVE_FINAL_DUTY         = duty_reg[1];
  assign PRESSURE_VALVE_CURRENT_ESTIMATE   = cur_reg[1];
  assign PRESSURE_VALVE_CHAN_DUTY          = cd_reg[1];
  assign PRESSURE_VALVE_CHAN_FREQ          = cf_reg[1];
  assign PRESSURE_VALVE_CHAN_ON            = on_reg[1];

endmodule
